// ===== core/uv_stage_block.sv
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
module uv_stage_block #(
  parameter logic [17:0] CYCLE_CLKS = 18'(uv_block_pkg::CYCLE_CLKS)
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  // register port
  input  wire logic [7:0]               addr_i,
  input  wire logic [31:0]              wdata_i,
  input  wire logic                     we_i,
  input  wire logic                     re_i,
  output logic [31:0]                   rdata_o,
  // measurement and blocking matrix
  input  wire uv_block_pkg::voltages_t  volt_i,
  input  wire logic                     block_in_i,
  // stage outputs
  output logic                          start_o,
  output logic                          blocked_o,
  output logic                          uv_block_o,
  output logic                          release_o,
  output logic                          display_evt_o,
  output logic                          block_evt_o,
  output uv_block_pkg::block_evt_t      evt_o,
  output logic                          irq_o
);

  typedef struct packed {
    logic                    sync1;
    logic                    sync2;
    logic                    blk;
    logic [17:0]             tick_cnt;
    logic                    eval;
    uv_block_pkg::voltages_t vm;
    logic                    inv_mode;
    logic [13:0]             pickup_set;
    logic [13:0]             block_set;
    logic [18:0]             op_delay;
    logic [12:0]             dial;
    logic [23:0]             vt_scale;
    logic                    pickup;
    logic                    start;
    logic                    blocked;
    logic                    uv_block;
    logic                    release_p;
    logic                    disp_evt;
    logic                    blk_evt;
    uv_block_pkg::block_evt_t evt;
    logic [2:0]              irq_stat;
    logic [2:0]              irq_mask;
    logic                    irq;
    uv_block_pkg::seq_state_t seq;
    logic [2:0]              op;
    logic                    div_start;
    logic [47:0]             div_dividend;
    logic [23:0]             div_divisor;
    logic [3:0][16:0]        ratio;
    logic [31:0]             pick_prim;
    logic [31:0]             blk_prim;
    logic [18:0]             exp_inv;
    logic [19:0]             elapsed;
    logic [31:0]             rdata;
  } stage_st_t;

  stage_st_t   q;
  stage_st_t   d;
  logic        div_done;
  logic [47:0] div_quo;

  // one shared divider keeps area small; a full pass takes well under one cycle
  uv_divider u_div (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .start_i    (q.div_start),
    .dividend_i (q.div_dividend),
    .divisor_i  (q.div_divisor),
    .done_o     (div_done),
    .quotient_o (div_quo)
  );

  // lowest of the three sampled voltages
  logic [15:0] vmin;
  assign vmin = (q.vm.a < q.vm.b) ? ((q.vm.a < q.vm.c) ? q.vm.a : q.vm.c)
                                  : ((q.vm.b < q.vm.c) ? q.vm.b : q.vm.c);

  logic [18:0] exp_time;
  logic [19:0] rem_time;
  assign exp_time = q.inv_mode ? q.exp_inv : q.op_delay;
  assign rem_time = {1'b0, exp_time} - q.elapsed;

  always_comb begin
    logic [2:0]  below;
    logic        pick_on;
    logic        pick_off;
    logic        new_pick;
    logic [2:0]  ev;
    logic [47:0] res;
    below    = {q.vm.c < 16'(q.pickup_set), q.vm.b < 16'(q.pickup_set),
                q.vm.a < 16'(q.pickup_set)};
    pick_on  = vmin < 16'(q.pickup_set);
    pick_off = 24'(vmin) * 24'(uv_block_pkg::PCT_FULL)
               > 24'(q.pickup_set) * 24'(uv_block_pkg::HYST_PCT);
    new_pick = q.pickup ? !pick_off : pick_on;
    res      = '0;
    ev       = '0;
    d           = q;
    d.release_p = 1'b0;
    d.disp_evt  = 1'b0;
    d.blk_evt   = 1'b0;
    d.div_start = 1'b0;
    d.rdata     = '0;

    // input synchroniser, second stage feeds the cycle sample only
    d.sync1 = block_in_i;
    d.sync2 = q.sync1;

    // a block later than one cycle before expiry may miss the trip
    d.eval = 1'b0;
    if (q.tick_cnt == CYCLE_CLKS - 18'h00001) begin
      d.tick_cnt = '0;
      d.blk      = q.sync2;
      d.vm       = volt_i;
      d.eval     = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 18'h00001;
    end

    // stage evaluation, one clock after the sample
    if (q.eval) begin
      d.pickup = new_pick;
      if (q.block_set == 14'h0000) begin
        d.uv_block = 1'b0;
      end else if (vmin < 16'(q.block_set)) begin
        d.uv_block = 1'b1;
      end else if (vmin > 16'(q.pickup_set)) begin
        d.uv_block = 1'b0;
      end
      if (new_pick) begin
        if (!q.pickup) begin
          d.start   = !q.blk;
          d.blocked = q.blk;
        end else if (q.start && q.blk) begin
          d.start     = 1'b0;
          d.release_p = 1'b1;
          d.blocked   = 1'b1;
        end
      end else begin
        d.release_p = q.start;
        d.start     = 1'b0;
        d.blocked   = 1'b0;
      end
      d.elapsed = (q.start && d.start) ? q.elapsed + 20'h00001 : '0;
      if (d.blocked && !q.blocked) begin
        d.disp_evt  = 1'b1;
        d.blk_evt   = 1'b1;
        d.evt.volt  = q.vm;
        d.evt.fault = below;
      end
    end

    // measurement sequencer through the shared divider
    case (q.seq)
      uv_block_pkg::SEQ_IDLE: begin
        if (q.eval) begin
          d.op  = 3'h0;
          d.seq = uv_block_pkg::SEQ_ISSUE;
        end
      end
      uv_block_pkg::SEQ_ISSUE: begin
        d.div_start   = 1'b1;
        d.div_divisor = 24'(q.pickup_set);
        d.seq         = uv_block_pkg::SEQ_WAIT;
        case (q.op)
          3'h0: d.div_dividend = 48'(q.vm.a) * 48'(uv_block_pkg::RATIO_SCALE);
          3'h1: d.div_dividend = 48'(q.vm.b) * 48'(uv_block_pkg::RATIO_SCALE);
          3'h2: d.div_dividend = 48'(q.vm.c) * 48'(uv_block_pkg::RATIO_SCALE);
          3'h3: d.div_dividend = 48'(vmin) * 48'(uv_block_pkg::RATIO_SCALE);
          3'h4: begin
            d.div_dividend = 48'(q.pickup_set) * 48'(q.vt_scale);
            d.div_divisor  = 24'(uv_block_pkg::VT_DIV);
          end
          3'h5: begin
            d.div_dividend = 48'(q.block_set) * 48'(q.vt_scale);
            d.div_divisor  = 24'(uv_block_pkg::VT_DIV);
          end
          default: begin
            // inverse time from present voltage, exponent fixed at one
            d.div_dividend = 48'(q.dial) * 48'(uv_block_pkg::TICKS_PER_DIAL)
                             * 48'(q.pickup_set);
            d.div_divisor  = pick_on ? 24'(q.pickup_set) - 24'(vmin) : 24'h000000;
          end
        endcase
      end
      uv_block_pkg::SEQ_WAIT: begin
        if (div_done) begin
          res = div_quo;
          // ratios saturate at the display ceiling
          if (q.op < 3'h4) begin
            d.ratio[q.op[1:0]] = (res > 48'(uv_block_pkg::RATIO_MAX))
                                 ? 17'(uv_block_pkg::RATIO_MAX) : res[16:0];
          end else if (q.op == 3'h4) begin
            d.pick_prim = (res[47:32] != 16'h0000) ? 32'hffffffff : res[31:0];
          end else if (q.op == 3'h5) begin
            d.blk_prim = (res[47:32] != 16'h0000) ? 32'hffffffff : res[31:0];
          end else begin
            d.exp_inv = (res > 48'(uv_block_pkg::EXP_MAX))
                        ? 19'(uv_block_pkg::EXP_MAX) : res[18:0];
          end
          if (q.op == 3'(uv_block_pkg::LAST_OP)) begin
            d.seq = uv_block_pkg::SEQ_IDLE;
          end else begin
            d.op  = q.op + 3'h1;
            d.seq = uv_block_pkg::SEQ_ISSUE;
          end
        end
      end
      default: d.seq = uv_block_pkg::SEQ_IDLE;
    endcase

    // register writes
    if (we_i) begin
      case (addr_i)
        uv_block_pkg::OFF_CTRL:     d.inv_mode   = wdata_i[uv_block_pkg::CTRL_INV_BIT];
        uv_block_pkg::OFF_PICKUP:   d.pickup_set = wdata_i[13:0];
        uv_block_pkg::OFF_BLOCK:    d.block_set  = wdata_i[13:0];
        uv_block_pkg::OFF_OP_DELAY: d.op_delay   = wdata_i[18:0];
        uv_block_pkg::OFF_DIAL:     d.dial       = wdata_i[12:0];
        uv_block_pkg::OFF_VT_SCALE: d.vt_scale   = wdata_i[23:0];
        uv_block_pkg::OFF_IRQ_MASK: d.irq_mask   = wdata_i[2:0];
        uv_block_pkg::OFF_IRQ_STAT: d.irq_stat   = q.irq_stat & ~wdata_i[2:0];
        default: ;
      endcase
    end

    // sticky events, a set in the clearing cycle wins
    ev = {d.uv_block & ~q.uv_block, d.blocked & ~q.blocked, d.start & ~q.start};
    d.irq_stat = d.irq_stat | ev;
    d.irq      = |(d.irq_stat & d.irq_mask);

    // register reads, data valid in the following cycle only
    if (re_i) begin
      case (addr_i)
        uv_block_pkg::OFF_CTRL:      d.rdata = 32'(q.inv_mode);
        uv_block_pkg::OFF_PICKUP:    d.rdata = 32'(q.pickup_set);
        uv_block_pkg::OFF_BLOCK:     d.rdata = 32'(q.block_set);
        uv_block_pkg::OFF_OP_DELAY:  d.rdata = 32'(q.op_delay);
        uv_block_pkg::OFF_DIAL:      d.rdata = 32'(q.dial);
        uv_block_pkg::OFF_VT_SCALE:  d.rdata = 32'(q.vt_scale);
        uv_block_pkg::OFF_STATUS:    d.rdata = 32'({q.pickup, q.uv_block, q.blocked, q.start});
        uv_block_pkg::OFF_IRQ_STAT:  d.rdata = 32'(q.irq_stat);
        uv_block_pkg::OFF_IRQ_MASK:  d.rdata = 32'(q.irq_mask);
        uv_block_pkg::OFF_EXP_TIME:  d.rdata = 32'(exp_time);
        uv_block_pkg::OFF_REM_TIME:  d.rdata = q.start ? {{12{rem_time[19]}}, rem_time} : '0;
        uv_block_pkg::OFF_RATIO_A:   d.rdata = 32'(q.ratio[0]);
        uv_block_pkg::OFF_RATIO_B:   d.rdata = 32'(q.ratio[1]);
        uv_block_pkg::OFF_RATIO_C:   d.rdata = 32'(q.ratio[2]);
        uv_block_pkg::OFF_RATIO_MIN: d.rdata = 32'(q.ratio[3]);
        uv_block_pkg::OFF_PICK_PRIM: d.rdata = q.pick_prim;
        uv_block_pkg::OFF_BLK_PRIM:  d.rdata = q.blk_prim;
        default:                     d.rdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q            <= '0;
      q.seq        <= uv_block_pkg::SEQ_IDLE;
      q.pickup_set <= uv_block_pkg::RST_PICKUP;
      q.block_set  <= uv_block_pkg::RST_BLOCK;
      q.op_delay   <= uv_block_pkg::RST_OP_DELAY;
      q.dial       <= uv_block_pkg::RST_DIAL;
      q.vt_scale   <= uv_block_pkg::RST_VT_SCALE;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign rdata_o       = q.rdata;
  assign start_o       = q.start;
  assign blocked_o     = q.blocked;
  assign uv_block_o    = q.uv_block;
  assign release_o     = q.release_p;
  assign display_evt_o = q.disp_evt;
  assign block_evt_o   = q.blk_evt;
  assign evt_o         = q.evt;
  assign irq_o         = q.irq;

  logic pick_off_chk;
  assign pick_off_chk = 32'(vmin) * 32'(uv_block_pkg::PCT_FULL)
                        > 32'(q.pickup_set) * 32'(uv_block_pkg::HYST_PCT);
  // checks
  a_blk_sample_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    !d.eval |=> $stable(q.blk)) else $error("block sample changed mid cycle");
  a_zero_level_off: assert property (@(posedge clk_i) disable iff (reset_i)
    q.eval && q.block_set == 14'h0000 |=> !uv_block_o) else $error("zero level blocked");
  a_low_volt_engage: assert property (@(posedge clk_i) disable iff (reset_i)
    q.eval && q.block_set != 14'h0000 && vmin < 16'(q.block_set) |=> uv_block_o)
    else $error("low voltage block missed");
  a_uv_latch_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    uv_block_o && !q.eval |=> uv_block_o) else $error("block released off cycle");
  a_start_not_blk: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(start_o) |-> !$past(q.blk) && $past(q.eval)) else $error("start while blocked");
  a_blocked_cause: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(blocked_o) |-> $past(q.blk) && !start_o) else $error("blocked without block");
  a_late_block_rel: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(start_o) |-> release_o ##1 !release_o) else $error("no release on start drop");
  a_block_evt_pair: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(blocked_o) |-> block_evt_o && display_evt_o && evt_o.volt == $past(q.vm))
    else $error("blocking event missing");
  a_hyst_keep: assert property (@(posedge clk_i) disable iff (reset_i)
    q.eval && q.pickup && !pick_off_chk |=> q.pickup) else $error("pick-up dropped early");

endmodule

// ===== core/uv_block_pkg.sv
package uv_block_pkg;

  // processing cycle timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CYCLE_TIME_NS = 5000000;
  localparam int unsigned CYCLE_CLKS    = CYCLE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W        = 18;

  // arithmetic scaling
  localparam int unsigned HYST_PCT       = 103;   // reset ratio of the pick-up comparator
  localparam int unsigned PCT_FULL       = 100;
  localparam int unsigned RATIO_SCALE    = 100;   // ratios in 0.01 steps
  localparam int unsigned VT_DIV         = 10000; // 0.01 %Un steps to full scale
  localparam int unsigned TICKS_PER_DIAL = 2;     // 0.01 s dial step in 5 ms units
  localparam int unsigned RATIO_MAX      = 125000;
  localparam int unsigned EXP_MAX        = 360000;
  localparam int unsigned DIV_STEPS      = 48;
  localparam int unsigned LAST_OP        = 6;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_PICKUP    = 8'h04;
  localparam logic [7:0] OFF_BLOCK     = 8'h08;
  localparam logic [7:0] OFF_OP_DELAY  = 8'h0c;
  localparam logic [7:0] OFF_DIAL      = 8'h10;
  localparam logic [7:0] OFF_VT_SCALE  = 8'h14;
  localparam logic [7:0] OFF_STATUS    = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h20;
  localparam logic [7:0] OFF_EXP_TIME  = 8'h24;
  localparam logic [7:0] OFF_REM_TIME  = 8'h28;
  localparam logic [7:0] OFF_RATIO_A   = 8'h2c;
  localparam logic [7:0] OFF_RATIO_B   = 8'h30;
  localparam logic [7:0] OFF_RATIO_C   = 8'h34;
  localparam logic [7:0] OFF_RATIO_MIN = 8'h38;
  localparam logic [7:0] OFF_PICK_PRIM = 8'h3c;
  localparam logic [7:0] OFF_BLK_PRIM  = 8'h40;

  // field positions
  localparam int unsigned CTRL_INV_BIT   = 0;
  localparam int unsigned ST_START_BIT   = 0;
  localparam int unsigned ST_BLOCKED_BIT = 1;
  localparam int unsigned ST_UVBLK_BIT   = 2;
  localparam int unsigned ST_PICKUP_BIT  = 3;
  localparam int unsigned IRQ_W          = 3;

  // reset values
  localparam logic [13:0] RST_PICKUP   = 14'h1770; // 60.00 %Un
  localparam logic [13:0] RST_BLOCK    = 14'h03e8; // 10.00 %Un
  localparam logic [18:0] RST_OP_DELAY = 19'h00008; // 0.040 s
  localparam logic [12:0] RST_DIAL     = 13'h0005;  // 0.05 s
  localparam logic [23:0] RST_VT_SCALE = 24'h0003e8; // plain default, 100.0 V

  // three monitored voltages, 0.01 %Un steps
  typedef struct packed {
    logic [15:0] c;
    logic [15:0] b;
    logic [15:0] a;
  } voltages_t;

  // blocking event payload
  typedef struct packed {
    voltages_t   volt;
    logic [2:0]  fault;
  } block_evt_t;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_ISSUE = 3'b010,
    SEQ_WAIT  = 3'b100
  } seq_state_t;

endpackage

// ===== core/uv_divider.sv
`timescale 1ns/1ps
module uv_divider (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // request
  input  wire logic        start_i,
  input  wire logic [47:0] dividend_i,
  input  wire logic [23:0] divisor_i,
  // answer
  output logic             done_o,
  output logic [47:0]      quotient_o
);

  typedef struct packed {
    logic        busy;
    logic [5:0]  cnt;
    logic [24:0] rem;
    logic [47:0] quo;
    logic [23:0] dvs;
    logic        done;
  } div_st_t;

  div_st_t q;
  div_st_t d;

  // restoring division, one bit per clock; a zero divisor yields all ones
  always_comb begin
    logic [24:0] trial;
    trial  = {q.rem[23:0], q.quo[47]};
    d      = q;
    d.done = 1'b0;
    if (start_i && !q.busy) begin
      d.busy = 1'b1;
      d.cnt  = 6'(uv_block_pkg::DIV_STEPS);
      d.rem  = '0;
      d.quo  = dividend_i;
      d.dvs  = divisor_i;
    end else if (q.busy) begin
      d.quo = {q.quo[46:0], 1'b0};
      if (trial >= {1'b0, q.dvs}) begin
        d.rem    = trial - {1'b0, q.dvs};
        d.quo[0] = 1'b1;
      end else begin
        d.rem = trial;
      end
      d.cnt = q.cnt - 6'h01;
      if (q.cnt == 6'h01) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_o     = q.done;
  assign quotient_o = q.quo;

endmodule

// ===== tb/uv_far_end.sv
`timescale 1ns/1ps
// stand-in for the blocking matrix and the measurement front end
module uv_far_end (
  // clock
  input  wire logic                    clk_i,
  // commands from the bench
  input  wire uv_block_pkg::voltages_t volt_cmd_i,
  input  wire logic                    block_cmd_i,
  // toward the stage
  output uv_block_pkg::voltages_t      volt_o,
  output logic                         block_o
);
  // defined levels before the first edge, so the stage never samples unknowns
  initial begin
    volt_o  = '0;
    block_o = 1'b0;
  end

  // early block
  // commands pass on one edge later, far ahead of any operating delay
  always @(posedge clk_i) begin
    volt_o  <= volt_cmd_i;
    block_o <= block_cmd_i;
  end
endmodule

// ===== tb/test_uv_stage_block.sv
`timescale 1ns/1ps
module test_uv_stage_block;
  // short processing cycle, long enough for the divider sequence
  localparam logic [17:0] CYC = 18'h001f4;

  logic                        clk = 1'b0;
  logic                        reset = 1'b1;
  logic                        we = 1'b0;
  logic                        re = 1'b0;
  logic                        blk = 1'b0;
  logic [7:0]                  addr = 8'h00;
  logic [31:0]                 wdata = 32'h0;
  logic [31:0]                 rdata;
  logic [31:0]                 v;
  logic [31:0]                 w;
  uv_block_pkg::voltages_t     vcmd = {16'h2ee0, 16'h2328, 16'h2710};
  uv_block_pkg::voltages_t     volt;
  uv_block_pkg::block_evt_t    evt;
  logic                        block_in;
  logic                        start;
  logic                        blocked;
  logic                        uvb;
  logic                        rel;
  logic                        disp;
  logic                        bevt;
  logic                        irq;
  int                          failures = 0;
  int                          check_count = 0;
  int                          n_rel = 0;
  int                          n_evt = 0;
  int                          r0;
  int                          e0;

  always #10 clk = ~clk;

  uv_far_end far (.clk_i(clk), .volt_cmd_i(vcmd), .block_cmd_i(blk), .volt_o(volt),
    .block_o(block_in));

  uv_stage_block #(.CYCLE_CLKS(CYC)) dut (.clk_i(clk), .reset_i(reset), .addr_i(addr),
    .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .volt_i(volt),
    .block_in_i(block_in), .start_o(start), .blocked_o(blocked), .uv_block_o(uvb),
    .release_o(rel), .display_evt_o(disp), .block_evt_o(bevt), .evt_o(evt), .irq_o(irq));

  // pulse counters; both event pulses must come in the same cycle
  always @(posedge clk) begin
    if (rel === 1'b1) n_rel++;
    if (disp === 1'b1) n_evt++;
    if (disp !== bevt) begin
      failures++;
      $display("ERROR %0t event pulses not paired", $time);
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // a change may just miss a tick, so allow three whole cycles
  task automatic settle;
    repeat (3 * int'(CYC)) @(posedge clk);
    // step off the edge so level outputs are read settled
    #1;
  endtask

  task automatic drive(input logic [15:0] a, b, c, input logic bk);
    @(posedge clk);
    vcmd <= {c, b, a};
    blk  <= bk;
    settle();
  endtask

  task automatic t_reset;
    rchk(uv_block_pkg::OFF_CTRL, 32'h0);
    rchk(uv_block_pkg::OFF_PICKUP, 32'h1770);
    rchk(uv_block_pkg::OFF_BLOCK, 32'h3e8);
    rchk(uv_block_pkg::OFF_OP_DELAY, 32'h8);
    rchk(uv_block_pkg::OFF_DIAL, 32'h5);
    rchk(uv_block_pkg::OFF_VT_SCALE, 32'h3e8);
    rchk(uv_block_pkg::OFF_IRQ_MASK, 32'h0);
    wr(uv_block_pkg::OFF_STATUS, 32'hf);
    rchk(uv_block_pkg::OFF_STATUS, 32'h0);
    rchk(8'hfc, 32'h0);
  endtask

  task automatic t_normal;
    drive(16'h2710, 16'h2328, 16'h2ee0, 1'b0);
    rchk(uv_block_pkg::OFF_RATIO_A, 32'ha6); // phase a
    rchk(uv_block_pkg::OFF_RATIO_B, 32'h96); // phase b
    rchk(uv_block_pkg::OFF_RATIO_C, 32'hc8); // phase c
    rchk(uv_block_pkg::OFF_RATIO_MIN, 32'h96); // lowest
    rchk(uv_block_pkg::OFF_PICK_PRIM, 32'h258); // pick-up
    rchk(uv_block_pkg::OFF_BLK_PRIM, 32'h64); // block
  endtask

  task automatic t_start;
    wr(uv_block_pkg::OFF_IRQ_MASK, 32'h1);
    drive(16'h0bb8, 16'h2328, 16'h2ee0, 1'b0);
    rchk(uv_block_pkg::OFF_STATUS, 32'h9); // start
    chk({31'h0, irq}, 32'h1);
    rchk(uv_block_pkg::OFF_EXP_TIME, 32'h8); // fixed
    rd(uv_block_pkg::OFF_REM_TIME, v);
    chk({31'h0, $signed(v) <= 8 && $signed(v) >= 4}, 32'h1); // counting
    settle();
    rd(uv_block_pkg::OFF_REM_TIME, w);
    chk({31'h0, $signed(w) < $signed(v)}, 32'h1); // falling
    wr(uv_block_pkg::OFF_CTRL, 32'h1);
    settle();
    rchk(uv_block_pkg::OFF_EXP_TIME, 32'h14); // inverse
    drive(16'h1194, 16'h2328, 16'h2ee0, 1'b0);
    rchk(uv_block_pkg::OFF_EXP_TIME, 32'h28); // follows
    wr(uv_block_pkg::OFF_CTRL, 32'h0);
    wr(uv_block_pkg::OFF_IRQ_STAT, 32'h1);
    rchk(uv_block_pkg::OFF_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_late_block;
    r0 = n_rel;
    e0 = n_evt;
    drive(16'h1194, 16'h2328, 16'h2ee0, 1'b1);
    rchk(uv_block_pkg::OFF_STATUS, 32'ha); // start dropped
    chk(32'(n_rel - r0), 32'h1); // release
    chk(32'(n_evt - e0), 32'h1); // one event
    chk(32'(evt.fault), 32'h1); // fault
    chk(32'(evt.volt.a), 32'h1194); // voltage
    // still above pick-up but inside the reset band
    drive(16'h17d4, 16'h2328, 16'h2ee0, 1'b1);
    rchk(uv_block_pkg::OFF_STATUS, 32'ha); // held
    drive(16'h1838, 16'h2328, 16'h2ee0, 1'b1);
    rchk(uv_block_pkg::OFF_STATUS, 32'h0); // released
    chk(32'(n_rel - r0), 32'h1);
  endtask

  task automatic t_early_block;
    r0 = n_rel;
    e0 = n_evt;
    drive(16'h0bb8, 16'h2328, 16'h2ee0, 1'b1);
    rchk(uv_block_pkg::OFF_STATUS, 32'ha); // blocked
    chk({31'h0, start}, 32'h0); // no start
    chk({31'h0, blocked}, 32'h1); // blocked pin
    chk(32'(n_evt - e0), 32'h1); // event
    chk(32'(n_rel - r0), 32'h0); // no timing
    drive(16'h2710, 16'h2328, 16'h2ee0, 1'b0);
    rchk(uv_block_pkg::OFF_STATUS, 32'h0);
  endtask

  task automatic t_uv;
    // the start bit rises again here, so its mask from the start scenario must go
    wr(uv_block_pkg::OFF_IRQ_MASK, 32'h0);
    drive(16'h01f4, 16'h2328, 16'h2ee0, 1'b0);
    chk({31'h0, uvb}, 32'h1); // engaged
    chk({31'h0, irq}, 32'h0);
    rd(uv_block_pkg::OFF_IRQ_STAT, v);
    chk(v & 32'h4, 32'h4);
    wr(uv_block_pkg::OFF_IRQ_MASK, 32'h4);
    settle();
    chk({31'h0, irq}, 32'h1);
    wr(uv_block_pkg::OFF_IRQ_STAT, 32'h7);
    settle();
    chk({31'h0, irq}, 32'h0);
    drive(16'h170c, 16'h2328, 16'h2ee0, 1'b0);
    chk({31'h0, uvb}, 32'h1); // latched
    drive(16'h1b58, 16'h2328, 16'h2ee0, 1'b0);
    chk({31'h0, uvb}, 32'h0); // released
    wr(uv_block_pkg::OFF_BLOCK, 32'h0);
    drive(16'h01f4, 16'h2328, 16'h2ee0, 1'b0);
    chk({31'h0, uvb}, 32'h0); // disabled
    rchk(uv_block_pkg::OFF_STATUS, 32'h9); // start
    drive(16'h2710, 16'h2328, 16'h2ee0, 1'b0);
    rchk(uv_block_pkg::OFF_STATUS, 32'h0);
  endtask

  task automatic print_verdict;
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_normal();
    t_start();
    t_late_block();
    t_early_block();
    t_uv();
    print_verdict();
  end
endmodule
